// ---- rtl/iocr_pin_cell.sv ----
// pin cell with input, output and 3-state storage elements and an AXI4-Lite slave
module iocr_pin_cell
   import iocr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   // AXI4-Lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // global pull-up choice from the configuration mode pins
   input wire logic cfg_mode_pullup,
   // fabric side
   input wire logic fab_o,
   input wire logic fab_t,
   input wire logic [2:0] fab_ce,
   input wire logic shared_set_reset,
   output logic fab_in,
   // pad side
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic pull_up_en,
   output logic pull_down_en,
   output logic keep_out,
   output logic keep_oe
);
   // ----------------------------------------------------------------
   // configuration state
   // ----------------------------------------------------------------
   logic [31:0] ctrl;
   logic [31:0] mode;
   logic cfg_done;
   logic [2:0] latch_sel;
   logic [2:0] reg_sel;
   logic [2:0] inv_ce;
   logic inv_out;
   logic inv_ts;
   logic inv_sr;
   logic keeper_sel;
   iocr_pull_t pull_sel;
   iocr_sr_mode_t sr_mode [IOCR_NUM_EL];

   assign cfg_done = ctrl[IOCR_CTRL_DONE];
   assign latch_sel = mode[IOCR_LATCH_LSB +: 3];
   assign reg_sel = mode[IOCR_REGSEL_LSB +: 3];
   assign inv_ce = mode[IOCR_INV_CE_LSB +: 3];
   assign inv_out = mode[IOCR_INV_OUT];
   assign inv_ts = mode[IOCR_INV_TS];
   assign inv_sr = mode[IOCR_INV_SR];
   assign keeper_sel = mode[IOCR_KEEPER];
   assign pull_sel = iocr_pull_t'(mode[IOCR_PULL_LSB +: 2]);

   // ----------------------------------------------------------------
   // storage elements
   // ----------------------------------------------------------------
   logic sr_eff;
   logic t_eff;
   logic [2:0] ce_eff;
   logic [2:0] el_d;
   logic [2:0] el_q;

   // every control input passes its own inversion
   assign sr_eff = shared_set_reset ^ inv_sr;
   assign ce_eff = fab_ce ^ inv_ce;
   assign t_eff = fab_t ^ inv_ts;
   assign el_d[IOCR_EL_IN] = pad_in;
   assign el_d[IOCR_EL_OUT] = fab_o;
   assign el_d[IOCR_EL_TS] = t_eff;

   // the three elements share ref_clk and set/reset, enables apart
   for (genvar g = 0; g < IOCR_NUM_EL; g++) begin : g_elem
      assign sr_mode[g] = iocr_sr_mode_t'(mode[IOCR_SRM_LSB + 2 * g +: 2]);
      iocr_store_elem u_elem (
         .ref_clk(ref_clk),
         .reset(reset),
         .latch_mode(latch_sel[g]),
         .sr_mode(sr_mode[g]),
         .ce(ce_eff[g]),
         .sr(sr_eff),
         .d(el_d[g]),
         .q(el_q[g])
      );
   end

   // ----------------------------------------------------------------
   // data and 3-state paths
   // ----------------------------------------------------------------
   logic drive_off;

   assign fab_in = reg_sel[IOCR_EL_IN] ? el_q[IOCR_EL_IN] : pad_in;
   // output path direct or registered, then buffer inversion
   assign pad_out = (reg_sel[IOCR_EL_OUT] ? el_q[IOCR_EL_OUT] : fab_o) ^ inv_out;
   // high 3-state control turns the driver off
   assign drive_off = reg_sel[IOCR_EL_TS] ? el_q[IOCR_EL_TS] : t_eff;
   // nothing drives until configuration is complete
   assign pad_oe = cfg_done && !drive_off;

   // ----------------------------------------------------------------
   // pulls and keeper
   // ----------------------------------------------------------------
   // before configuration only the global pull-up may be on
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pull_up_en <= 1'b0;
         pull_down_en <= 1'b0;
      end else if (!cfg_done) begin
         pull_up_en <= cfg_mode_pullup;
         pull_down_en <= 1'b0;
      end else begin
         pull_up_en <= (pull_sel == IOCR_PULL_UP);
         pull_down_en <= (pull_sel == IOCR_PULL_DOWN);
      end
   end

   // keeper follows the pad and drives weakly while our driver is off
   // the level is sampled every cycle, so it holds what the pad last showed
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         keep_out <= 1'b0;
         keep_oe <= 1'b0;
      end else begin
         keep_out <= pad_in;
         keep_oe <= cfg_done && keeper_sel && drive_off;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write side
   // ----------------------------------------------------------------
   logic aw_held;
   logic w_held;
   logic [3:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_go;

   // address and data may arrive in either order; each is held until used
   assign wr_go = aw_held && w_held && !s_axi_bvalid;

   // address capture
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         aw_held <= 1'b0;
         wr_addr <= 4'h0;
         s_axi_awready <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      end
   end

   // data capture
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         w_held <= 1'b0;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
         s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      end
   end

   // merge a word under its byte strobes
   function automatic logic [31:0] iocr_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8 * i +: 8] = nw[8 * i +: 8];
         end
      end
      return res;
   endfunction : iocr_merge

   // register update; status is read only, so a write there is refused
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ctrl <= IOCR_CTRL_RST;
         mode <= IOCR_MODE_RST;
      end else if (wr_go) begin
         if (wr_addr == IOCR_CTRL_OFS) begin
            ctrl <= iocr_merge(ctrl, wr_data, wr_strb) & 32'h0000_0001;
         end
         if (wr_addr == IOCR_MODE_OFS) begin
            mode <= iocr_merge(mode, wr_data, wr_strb) & 32'h001F_FFFF;
         end
      end
   end

   // write response
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= IOCR_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_addr == IOCR_CTRL_OFS || wr_addr == IOCR_MODE_OFS)
            ? IOCR_RESP_OKAY : IOCR_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read side
   // ----------------------------------------------------------------
   logic [31:0] status;

   // live view of the cell: done, element values, pad, drive, pulls
   assign status = {23'h00_0000, keep_oe, pull_down_en, pull_up_en, pad_oe, pad_in,
      el_q, cfg_done};

   // one read in flight; arready drops while the answer waits
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= IOCR_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= IOCR_RESP_OKAY;
         unique case (s_axi_araddr)
            IOCR_CTRL_OFS: s_axi_rdata <= ctrl;
            IOCR_MODE_OFS: s_axi_rdata <= mode;
            IOCR_STAT_OFS: s_axi_rdata <= status;
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= IOCR_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   // a_preconfig_hiz
   a_preconfig_hiz: assert property (@(posedge ref_clk) disable iff (reset)
      !cfg_done |-> !pad_oe) else $error("pin driven before configuration");

   // a_preconfig_pulls
   a_preconfig_pulls: assert property (@(posedge ref_clk) disable iff (reset)
      !cfg_done ##1 !cfg_done |-> !pull_down_en && !keep_oe
      && pull_up_en == $past(cfg_mode_pullup)) else $error("pull wrong before config");

   // a_pull_select
   a_pull_select: assert property (@(posedge ref_clk) disable iff (reset)
      cfg_done && pull_sel == IOCR_PULL_DOWN |=> pull_down_en && !pull_up_en)
      else $error("pull-down not applied");

   // a_keeper_hold
   a_keeper_hold: assert property (@(posedge ref_clk) disable iff (reset)
      cfg_done && keeper_sel && !pad_oe |=> keep_oe && keep_out == $past(pad_in))
      else $error("keeper not holding pad level");

   // a_input_direct
   a_input_direct: assert property (@(posedge ref_clk) disable iff (reset)
      !reg_sel[IOCR_EL_IN] |-> fab_in == pad_in) else $error("input bypass wrong");

   // a_input_reg
   a_input_reg: assert property (@(posedge ref_clk) disable iff (reset)
      reg_sel[IOCR_EL_IN] && !latch_sel[IOCR_EL_IN] && ce_eff[IOCR_EL_IN] && !sr_eff
      ##1 $stable(mode) && !sr_eff |-> fab_in == $past(pad_in))
      else $error("input element did not capture pad");

   // a_output_polarity
   a_output_polarity: assert property (@(posedge ref_clk) disable iff (reset)
      !reg_sel[IOCR_EL_OUT] |-> pad_out == (fab_o ^ inv_out))
      else $error("output path or inversion wrong");

   // a_ce_hold
   a_ce_hold: assert property (@(posedge ref_clk) disable iff (reset)
      !latch_sel[IOCR_EL_OUT] && !ce_eff[IOCR_EL_OUT] && !sr_eff ##1
      $stable(mode) && !sr_eff |-> $stable(el_q[IOCR_EL_OUT]))
      else $error("output element moved without enable");

   // a_ts_sync
   a_ts_sync: assert property (@(posedge ref_clk) disable iff (reset)
      cfg_done && reg_sel[IOCR_EL_TS] && !latch_sel[IOCR_EL_TS] && ce_eff[IOCR_EL_TS]
      && !sr_eff ##1 $stable(mode) && $stable(ctrl) && !sr_eff |-> pad_oe == !$past(t_eff))
      else $error("registered 3-state did not follow");

   // a_bresp_after: write answers once both halves are in
   a_bresp_after: assert property (@(posedge ref_clk) disable iff (reset)
      wr_go |=> s_axi_bvalid) else $error("write response missing");

   c_keeper_on: cover property (@(posedge ref_clk) disable iff (reset) keep_oe);
   c_latch_in: cover property (@(posedge ref_clk) disable iff (reset)
      latch_sel[IOCR_EL_IN] && reg_sel[IOCR_EL_IN] && fab_in);
   c_async_sr: cover property (@(posedge ref_clk) disable iff (reset)
      sr_eff && sr_mode[IOCR_EL_OUT] == IOCR_SR_ASYNC_PRE);
   c_drive: cover property (@(posedge ref_clk) disable iff (reset) pad_oe && pad_out);
endmodule : iocr_pin_cell

// ---- rtl/iocr_pkg.sv ----
// shared constants and types for the pin cell register block
package iocr_pkg;
   // ----------------------------------------------------------------
   // register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [3:0] IOCR_CTRL_OFS = 4'h0;
   localparam logic [3:0] IOCR_MODE_OFS = 4'h4;
   localparam logic [3:0] IOCR_STAT_OFS = 4'h8;
   localparam logic [31:0] IOCR_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] IOCR_MODE_RST = 32'h0000_0000;
   // ----------------------------------------------------------------
   // element indices and mode field positions
   // ----------------------------------------------------------------
   localparam int IOCR_EL_IN = 0;
   localparam int IOCR_EL_OUT = 1;
   localparam int IOCR_EL_TS = 2;
   localparam int IOCR_NUM_EL = 3;
   localparam int IOCR_CTRL_DONE = 0;
   localparam int IOCR_LATCH_LSB = 0;
   localparam int IOCR_SRM_LSB = 3;
   localparam int IOCR_REGSEL_LSB = 9;
   localparam int IOCR_INV_OUT = 12;
   localparam int IOCR_INV_TS = 13;
   localparam int IOCR_INV_SR = 14;
   localparam int IOCR_INV_CE_LSB = 15;
   localparam int IOCR_PULL_LSB = 18;
   localparam int IOCR_KEEPER = 20;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      IOCR_SR_SYNC_SET = 2'h0,
      IOCR_SR_SYNC_RST = 2'h1,
      IOCR_SR_ASYNC_CLR = 2'h2,
      IOCR_SR_ASYNC_PRE = 2'h3
   } iocr_sr_mode_t;
   typedef enum logic [1:0] {
      IOCR_PULL_NONE = 2'h0,
      IOCR_PULL_UP = 2'h1,
      IOCR_PULL_DOWN = 2'h2,
      IOCR_PULL_RSVD = 2'h3
   } iocr_pull_t;
   localparam logic [1:0] IOCR_RESP_OKAY = 2'h0;
   localparam logic [1:0] IOCR_RESP_SLVERR = 2'h2;
endpackage : iocr_pkg

// ---- rtl/iocr_store_elem.sv ----
// one storage element of the pin cell: flip-flop or latch with shared set/reset
module iocr_store_elem
   import iocr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic latch_mode,
   input wire iocr_sr_mode_t sr_mode,
   input wire logic ce,
   input wire logic sr,
   input wire logic d,
   output logic q
);
   logic ff_q;
   logic lat_q;
   logic async_clr;
   logic async_pre;

   // asynchronous forms of the shared set/reset
   assign async_clr = sr && (sr_mode == IOCR_SR_ASYNC_CLR);
   assign async_pre = sr && (sr_mode == IOCR_SR_ASYNC_PRE);

   // async clear and preset act at once and hold while asserted
   always_ff @(posedge ref_clk or posedge reset or posedge async_clr or posedge async_pre) begin
      if (reset || async_clr) begin
         ff_q <= 1'b0;
      end else if (async_pre) begin
         ff_q <= 1'b1;
      // synchronous set/reset wins over the clock enable
      end else if (sr) begin
         ff_q <= (sr_mode == IOCR_SR_SYNC_SET);
      // own clock enable gates the update
      end else if (ce) begin
         ff_q <= d;
      end
   end

   // level form, transparent while the clock is high
   always_latch begin
      if (reset || async_clr) begin
         lat_q <= 1'b0;
      end else if (async_pre) begin
         lat_q <= 1'b1;
      end else if (ref_clk) begin
         if (sr) begin
            lat_q <= (sr_mode == IOCR_SR_SYNC_SET);
         end else if (ce) begin
            lat_q <= d;
         end
      end
   end

   assign q = latch_mode ? lat_q : ff_q;

   // a_async_clear_now
   a_async_clear_now: assert property (@(posedge ref_clk) disable iff (reset)
      async_clr |-> !q) else $error("async clear did not force zero");
   // a_sync_set_edge
   a_sync_set_edge: assert property (@(posedge ref_clk) disable iff (reset)
      !latch_mode && sr && sr_mode == IOCR_SR_SYNC_SET ##1 !latch_mode |-> q)
      else $error("sync set did not set element");
endmodule : iocr_store_elem

// ---- dv/iocr_pad_model.sv ----
// behavioural model of the package pad and any other party on the pin
module iocr_pad_model
   import iocr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic pad_out,
   input wire logic pad_oe,
   input wire logic pull_up_en,
   input wire logic pull_down_en,
   input wire logic keep_out,
   input wire logic keep_oe,
   input wire logic ext_en,
   input wire logic ext_val,
   output logic pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // a floating pad flips each cycle so a missing hold never passes by luck
   logic float_v = 1'b0;
   always_ff @(posedge ref_clk) begin
      float_v <= ~pad_in;
   end
   // keeper holds level
   // strong drivers win over the keeper, keeper over pulls, pulls over floating
   always_comb begin
      if (pad_oe) begin
         pad_in = pad_out;
      end else if (ext_en) begin
         pad_in = ext_val;
      end else if (keep_oe) begin
         pad_in = keep_out;
      end else if (pull_up_en) begin
         pad_in = 1'b1;
      end else if (pull_down_en) begin
         pad_in = 1'b0;
      end else begin
         pad_in = float_v;
      end
   end
endmodule : iocr_pad_model

// ---- dv/testbench.sv ----
// self-checking bench for the pin cell: register access, paths, elements, pulls
module testbench
   import iocr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic cfg_mode_pullup = 1'b1, fab_o = 1'b0, fab_t = 1'b0, shared_set_reset = 1'b0;
   logic [2:0] fab_ce = 3'h0;
   logic ext_en = 1'b0, ext_val = 1'b0;
   logic fab_in, pad_in, pad_out, pad_oe, pull_up_en, pull_down_en, keep_out, keep_oe;
   logic [31:0] rd;
   int fails = 0;
   int checks = 0;
   always #5 ref_clk = ~ref_clk;
   iocr_pin_cell u_dut (.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .cfg_mode_pullup(cfg_mode_pullup), .fab_o(fab_o), .fab_t(fab_t), .fab_ce(fab_ce),
      .shared_set_reset(shared_set_reset), .fab_in(fab_in), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pull_up_en),
      .pull_down_en(pull_down_en), .keep_out(keep_out), .keep_oe(keep_oe));
   iocr_pad_model u_pad (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
      .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .keep_out(keep_out),
      .keep_oe(keep_oe), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
   // ----------------------------------------------------------------
   // bus tasks and comparison
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // write: address and data offered together, each released when taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      @(posedge ref_clk);
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge ref_clk);
         if (!aw_done && s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rdr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rdr
   task automatic stop_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test
   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      #50000;
      fails++;
      stop_test();
   end
   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      // before configuration: pin off, only global pull-up
      rdr(IOCR_CTRL_OFS, rd, resp);
      check(rd, IOCR_CTRL_RST);
      wr(IOCR_MODE_OFS, (32'h2 << IOCR_PULL_LSB) | (32'h1 << IOCR_KEEPER), resp);
      rdr(IOCR_MODE_OFS, rd, resp);
      check(rd, (32'h2 << IOCR_PULL_LSB) | (32'h1 << IOCR_KEEPER));
      // look past the edge so the pull registers have settled
      #1;
      check(32'(pad_oe), 32'h0);
      check(32'(pull_up_en), 32'h1);
      check(32'(pull_down_en), 32'h0);
      check(32'(keep_oe), 32'h0);
      @(posedge ref_clk);
      cfg_mode_pullup <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      check(32'(pull_up_en), 32'h0);
      // unmapped and read-only places are refused
      rdr(4'hC, rd, resp);
      check(rd, 32'h0);
      check(32'(resp), 32'(IOCR_RESP_SLVERR));
      wr(IOCR_STAT_OFS, 32'h1, resp);
      check(32'(resp), 32'(IOCR_RESP_SLVERR));
      wr(IOCR_MODE_OFS, 32'h0, resp);
      wr(IOCR_CTRL_OFS, 32'h1, resp);
      check(32'(resp), 32'(IOCR_RESP_OKAY));
      rdr(IOCR_STAT_OFS, rd, resp);
      check(32'(rd[IOCR_CTRL_DONE]), 32'h1);
      @(posedge ref_clk);
      fab_o <= 1'b1;
      fab_ce <= 3'h7;
      #1;
      check(32'(pad_out), 32'h1);
      check(32'(pad_oe), 32'h1);
      check(32'(fab_in), 32'h1);
      @(posedge ref_clk);
      fab_t <= 1'b1;
      ext_en <= 1'b1;
      #1;
      check(32'(pad_oe), 32'h0);
      check(32'(fab_in), 32'h0);
      // registered paths, clock enable, sync reset
      wr(IOCR_MODE_OFS, (32'h7 << IOCR_REGSEL_LSB) | 32'hA8, resp);
      @(posedge ref_clk);
      fab_o <= 1'b0;
      fab_t <= 1'b0;
      ext_en <= 1'b0;
      repeat (2) @(posedge ref_clk);
      fab_o <= 1'b1;
      #1;
      check(32'(pad_out), 32'h0);
      check(32'(pad_oe), 32'h1);
      @(posedge ref_clk);
      #1;
      check(32'(pad_out), 32'h1);
      check(32'(fab_in), 32'h0);
      @(posedge ref_clk);
      fab_ce <= 3'h5;
      fab_o <= 1'b0;
      #1;
      check(32'(fab_in), 32'h1);
      repeat (2) @(posedge ref_clk);
      fab_ce <= 3'h7;
      #1;
      check(32'(pad_out), 32'h1);
      @(posedge ref_clk);
      fab_o <= 1'b1;
      #1;
      check(32'(pad_out), 32'h0);
      @(posedge ref_clk);
      shared_set_reset <= 1'b1;
      #1;
      check(32'(pad_out), 32'h1);
      @(posedge ref_clk);
      shared_set_reset <= 1'b0;
      #1;
      check(32'(pad_out), 32'h0);
      // async preset on output, async clear on 3-state
      wr(IOCR_MODE_OFS, (32'h7 << IOCR_REGSEL_LSB) | 32'h168, resp);
      @(posedge ref_clk);
      fab_o <= 1'b0;
      fab_t <= 1'b1;
      repeat (2) @(posedge ref_clk);
      shared_set_reset <= 1'b1;
      #1;
      check(32'(pad_out), 32'h1);
      check(32'(pad_oe), 32'h1);
      repeat (2) @(posedge ref_clk);
      shared_set_reset <= 1'b0;
      #1;
      check(32'(pad_out), 32'h1);
      @(posedge ref_clk);
      #1;
      check(32'(pad_out), 32'h0);
      check(32'(pad_oe), 32'h0);
      // inverted output, 3-state, set/reset and clock enable
      wr(IOCR_MODE_OFS, (32'h1 << IOCR_INV_OUT) | (32'h1 << IOCR_INV_TS), resp);
      #1;
      check(32'(pad_out), 32'h1);
      check(32'(pad_oe), 32'h1);
      @(posedge ref_clk);
      fab_ce <= 3'h5;
      shared_set_reset <= 1'b1;
      wr(IOCR_MODE_OFS, (32'h2 << IOCR_REGSEL_LSB) | (32'h1 << IOCR_INV_SR) |
         (32'h2 << IOCR_INV_CE_LSB) | 32'h20, resp);
      @(posedge ref_clk);
      fab_o <= 1'b1;
      shared_set_reset <= 1'b0;
      #1;
      check(32'(pad_out), 32'h0);
      @(posedge ref_clk);
      fab_ce <= 3'h7;
      fab_o <= 1'b0;
      #1;
      check(32'(pad_out), 32'h0);
      // latch is transparent while the clock is high
      wr(IOCR_MODE_OFS, 32'h2 | (32'h2 << IOCR_REGSEL_LSB) | 32'h20, resp);
      repeat (2) @(posedge ref_clk);
      fab_o <= 1'b1;
      #1;
      check(32'(pad_out), 32'h1);
      wr(IOCR_MODE_OFS, 32'h1 << IOCR_PULL_LSB, resp);
      @(posedge ref_clk);
      #1;
      check(32'(pull_up_en), 32'h1);
      check(32'(pull_down_en), 32'h0);
      wr(IOCR_MODE_OFS, 32'h2 << IOCR_PULL_LSB, resp);
      @(posedge ref_clk);
      // keeper holds the last level once every driver lets go
      fab_t <= 1'b1;
      ext_en <= 1'b1;
      ext_val <= 1'b1;
      #1;
      check(32'(pull_up_en), 32'h0);
      check(32'(pull_down_en), 32'h1);
      wr(IOCR_MODE_OFS, 32'h1 << IOCR_KEEPER, resp);
      ext_en <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      check(32'(keep_oe), 32'h1);
      check(32'(keep_out), 32'h1);
      check(32'(fab_in), 32'h1);
      @(posedge ref_clk);
      ext_en <= 1'b1;
      ext_val <= 1'b0;
      repeat (2) @(posedge ref_clk);
      ext_en <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      check(32'(fab_in), 32'h0);
      @(posedge ref_clk);
      fab_t <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      check(32'(keep_oe), 32'h0);
      stop_test();
   end
endmodule : testbench
